//--- verilog/pamr_pkg.sv
/*
  constants of the auto-negotiation management register set: offsets,
  field positions, write masks and reset values.
  assumes a single 10 MHz management clock and 16-bit registers.
*/
package pamr_pkg;
  // register offsets
  localparam logic [4:0] ADDR_IDENT = 5'h03;
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam logic [4:0] ADDR_EXP = 5'h06;
  localparam logic [4:0] ADDR_NPTX = 5'h07;
  // identifier fields, values arbitrary
  localparam logic [5:0] ID_ORG_FRAG = 6'h15;
  localparam logic [5:0] ID_MODEL = 6'h22;
  localparam logic [3:0] ID_REV = 4'h3;
  // advertisement layout
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_RSV14_BIT = 14;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_RSV12_BIT = 12;
  localparam int ADV_ASYM_BIT = 11;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_T4_BIT = 9;
  localparam logic [15:0] ADV_WR_MASK = 16'hADFF;
  localparam logic [15:0] ADV_RST = 16'h01E1;
  // partner word: bit 12 forced low
  localparam int PART_NP_BIT = 15;
  localparam int PART_RSV_BIT = 12;
  localparam logic [15:0] PART_MASK = 16'hEFFF;
  localparam logic [15:0] PART_RST = 16'h0000;
  // expansion layout
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_NPC_BIT = 2;
  localparam int EXP_PR_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  localparam logic EXP_PDF_RST = 1'b0;
  localparam logic EXP_NPC_RST = 1'b1;
  localparam logic EXP_PR_RST = 1'b0;
  // next-page transmit layout
  localparam int NP_MORE_BIT = 15;
  localparam int NP_RSV_BIT = 14;
  localparam int NP_MSG_BIT = 13;
  localparam logic [15:0] NP_WR_MASK = 16'hA000;
  localparam logic [15:0] NP_RST = 16'h2000;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

//--- verilog/pamr_latch_flag.sv
/*
  one latching-high status flag.
  assumes set and clear come from logic on sys_clk.
*/
`timescale 1ns/1ps
module pamr_latch_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic set_cond,
  input wire logic rd_clear,
  output logic flag_ff
);
  logic nxt_flag;

  // set wins over the read that clears
  always_comb begin
    nxt_flag = set_cond | (flag_ff & ~rd_clear);
  end

  // flag storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  a_flag_clears: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rd_clear && !set_cond |=> !flag_ff)
    else $error("flag did not clear on read");
endmodule

//--- verilog/pamr_regs.sv
/*
  management register set for identifier, advertisement, partner page,
  expansion and next-page transmit words.
  assumes the frame engine gives one-cycle read and write strobes with a
  5-bit register address, and the negotiation engine runs on sys_clk.
*/
`timescale 1ns/1ps
module pamr_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  output logic [15:0] mgmt_rdata_ff,
  output logic mgmt_rvalid_ff,
  input wire logic an_complete,
  input wire logic partner_page_valid,
  input wire logic [15:0] partner_page,
  input wire logic partner_an_able,
  input wire logic page_received,
  input wire logic par_det_fault,
  input wire logic local_np_capable,
  output logic an_restart_ff,
  output logic [15:0] adv_word_ff,
  output logic [15:0] np_tx_word_ff
);
  logic [15:0] ident_ff;
  logic [15:0] partner_ff;
  logic partner_an_ff;
  logic [15:0] nxt_rdata;
  logic wr_adv;
  logic wr_np;
  logic rd_exp;
  logic pdf_flag;
  logic npc_flag;
  logic pr_flag;
  logic [15:0] exp_word;

  // true when a strobe addresses the given register
  function automatic logic reg_hit(input logic [4:0] addr,
                                   input logic [4:0] target);
    reg_hit = (addr == target);
  endfunction

  // strobe decode
  assign wr_adv = mgmt_wr & reg_hit(mgmt_addr, pamr_pkg::ADDR_ADV);
  assign wr_np = mgmt_wr & reg_hit(mgmt_addr, pamr_pkg::ADDR_NPTX);
  assign rd_exp = mgmt_rd & reg_hit(mgmt_addr, pamr_pkg::ADDR_EXP);

  // identifier word is a constant loaded at reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ident_ff <= {pamr_pkg::ID_ORG_FRAG, pamr_pkg::ID_MODEL,
                   pamr_pkg::ID_REV};
    end else begin
      ident_ff <= ident_ff;
    end
  end

  // advertisement: only writable bits take the write data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adv_word_ff <= pamr_pkg::ADV_RST;
    end else if (wr_adv) begin
      adv_word_ff <= mgmt_wdata & pamr_pkg::ADV_WR_MASK;
    end else begin
      adv_word_ff <= adv_word_ff;
    end
  end
  // bits 15, 13, 11, 10 go straight out to the page builder

  // restart pulse after an early advertisement write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      an_restart_ff <= 1'b0;
    end else begin
      an_restart_ff <= wr_adv & ~an_complete;
    end
  end
  // the manager is expected to finish its setup before completion

  // partner base page captured from the negotiation engine
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      partner_ff <= pamr_pkg::PART_RST;
    end else if (partner_page_valid) begin
      partner_ff <= partner_page & pamr_pkg::PART_MASK;
    end else begin
      partner_ff <= partner_ff;
    end
  end

  // partner negotiation ability
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      partner_an_ff <= 1'b0;
    end else begin
      partner_an_ff <= partner_an_able;
    end
  end

  // latched expansion events, cleared by a read of that register
  pamr_latch_flag #(
    .RST_VAL(pamr_pkg::EXP_PDF_RST)
  ) u_pdf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_cond(par_det_fault),
    .rd_clear(rd_exp),
    .flag_ff(pdf_flag)
  );

  pamr_latch_flag #(
    .RST_VAL(pamr_pkg::EXP_NPC_RST)
  ) u_npc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_cond(local_np_capable),
    .rd_clear(rd_exp),
    .flag_ff(npc_flag)
  );

  pamr_latch_flag #(
    .RST_VAL(pamr_pkg::EXP_PR_RST)
  ) u_pr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_cond(page_received),
    .rd_clear(rd_exp),
    .flag_ff(pr_flag)
  );

  // expansion word, upper bits held at zero
  always_comb begin
    exp_word = pamr_pkg::ZERO16;
    exp_word[pamr_pkg::EXP_PDF_BIT] = pdf_flag;
    exp_word[pamr_pkg::EXP_LPNP_BIT] =
      partner_ff[pamr_pkg::PART_NP_BIT];
    exp_word[pamr_pkg::EXP_NPC_BIT] = npc_flag;
    exp_word[pamr_pkg::EXP_PR_BIT] = pr_flag;
    exp_word[pamr_pkg::EXP_LPAN_BIT] = partner_an_ff;
  end

  // next-page transmit word: bits 15 and 13 are kept
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      np_tx_word_ff <= pamr_pkg::NP_RST;
    end else if (wr_np) begin
      np_tx_word_ff <= mgmt_wdata & pamr_pkg::NP_WR_MASK;
    end else begin
      np_tx_word_ff <= np_tx_word_ff;
    end
  end

  // read multiplexer; unmapped offsets answer zero
  always_comb begin
    nxt_rdata = pamr_pkg::ZERO16;
    if (reg_hit(mgmt_addr, pamr_pkg::ADDR_IDENT)) begin
      nxt_rdata = ident_ff;
    end else if (reg_hit(mgmt_addr, pamr_pkg::ADDR_ADV)) begin
      nxt_rdata = adv_word_ff;
    end else if (reg_hit(mgmt_addr, pamr_pkg::ADDR_PARTNER)) begin
      nxt_rdata = partner_ff;
    end else if (reg_hit(mgmt_addr, pamr_pkg::ADDR_EXP)) begin
      nxt_rdata = exp_word;
    end else if (reg_hit(mgmt_addr, pamr_pkg::ADDR_NPTX)) begin
      nxt_rdata = np_tx_word_ff;
    end
  end

  // read data held until the next read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mgmt_rdata_ff <= pamr_pkg::ZERO16;
      mgmt_rvalid_ff <= 1'b0;
    end else begin
      mgmt_rvalid_ff <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata_ff <= nxt_rdata;
      end
    end
  end

  // named steps of an early write and of a latched event
  sequence s_early_adv_write;
    wr_adv && !an_complete;
  endsequence

  sequence s_fault_then_no_read;
    par_det_fault ##1 !rd_exp;
  endsequence

  property p_restart_after_write;
    @(posedge sys_clk) disable iff (!rst_n)
    s_early_adv_write ##1 !wr_adv |-> an_restart_ff ##1 !an_restart_ff;
  endproperty

  property p_fault_latched;
    @(posedge sys_clk) disable iff (!rst_n)
    s_fault_then_no_read |=> pdf_flag;
  endproperty

  a_restart_early: assert property (p_restart_after_write)
    else $error("no single restart pulse after early write");

  a_no_restart_late: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    mgmt_wr && mgmt_addr == pamr_pkg::ADDR_ADV && an_complete
    |=> !an_restart_ff)
    else $error("restart after write with negotiation complete");

  a_adv_kept: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !wr_adv |=> $stable(adv_word_ff))
    else $error("advertisement changed without a write");

  a_adv_zero_bits: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !adv_word_ff[pamr_pkg::ADV_RSV14_BIT]
    && !adv_word_ff[pamr_pkg::ADV_RSV12_BIT]
    && !adv_word_ff[pamr_pkg::ADV_T4_BIT])
    else $error("advertisement reserved bit set");

  a_adv_write_bits: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    wr_adv |=> adv_word_ff[pamr_pkg::ADV_NP_BIT]
    == $past(mgmt_wdata[pamr_pkg::ADV_NP_BIT])
    && adv_word_ff[pamr_pkg::ADV_PAUSE_BIT]
    == $past(mgmt_wdata[pamr_pkg::ADV_PAUSE_BIT]))
    else $error("advertisement write not stored");

  a_part_capture: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    partner_page_valid |=> partner_ff
    == ($past(partner_page) & pamr_pkg::PART_MASK))
    else $error("partner page not captured");

  a_part_rsv_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !partner_ff[pamr_pkg::PART_RSV_BIT])
    else $error("partner reserved bit set");

  a_fault_latch: assert property (p_fault_latched)
    else $error("parallel fault flag lost");

  a_exp_readback: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rd_exp |=> mgmt_rvalid_ff && mgmt_rdata_ff[15:5] == 11'h000
    && mgmt_rdata_ff[pamr_pkg::EXP_LPNP_BIT]
    == $past(partner_ff[pamr_pkg::PART_NP_BIT]))
    else $error("expansion read data wrong");

  a_np_rsv_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !np_tx_word_ff[pamr_pkg::NP_RSV_BIT]
    && np_tx_word_ff[12:0] == 13'h0000)
    else $error("next-page read-only bit set");

  a_ident_const: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    mgmt_rd && mgmt_addr == pamr_pkg::ADDR_IDENT |=> mgmt_rdata_ff
    == {pamr_pkg::ID_ORG_FRAG, pamr_pkg::ID_MODEL,
        pamr_pkg::ID_REV})
    else $error("identifier read wrong");

  // named steps of a received page that is not yet read
  sequence s_page_then_no_read;
    page_received ##1 !rd_exp;
  endsequence

  sequence s_read_without_events;
    rd_exp && !page_received && !par_det_fault;
  endsequence

  property p_page_latched;
    @(posedge sys_clk) disable iff (!rst_n)
    s_page_then_no_read |=> pr_flag;
  endproperty

  property p_read_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    s_read_without_events |=> !pr_flag && !pdf_flag;
  endproperty

  // restart only ever follows an early advertisement write
  a_restart_needs_write: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !(wr_adv && !an_complete) |=> !an_restart_ff)
    else $error("restart without an early write");

  // fault and asymmetric pause flags take the write data
  a_adv_fault_pause: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    wr_adv |=> adv_word_ff[pamr_pkg::ADV_RF_BIT]
    == $past(mgmt_wdata[pamr_pkg::ADV_RF_BIT])
    && adv_word_ff[pamr_pkg::ADV_ASYM_BIT]
    == $past(mgmt_wdata[pamr_pkg::ADV_ASYM_BIT]))
    else $error("fault or pause flag not stored");

  // ability bits and selector field take the write data
  a_adv_ability_sel: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    wr_adv |=> adv_word_ff[8:0] == $past(mgmt_wdata[8:0]))
    else $error("ability or selector not stored");

  // advertisement, next-page and partner words and the three expansion flags at their reset values after a reset edge
  a_reset_values: assert property (@(posedge sys_clk)
    !rst_n |=> adv_word_ff == pamr_pkg::ADV_RST
    && np_tx_word_ff == pamr_pkg::NP_RST
    && partner_ff == pamr_pkg::PART_RST
    && pdf_flag == pamr_pkg::EXP_PDF_RST
    && pr_flag == pamr_pkg::EXP_PR_RST
    && npc_flag == pamr_pkg::EXP_NPC_RST)
    else $error("register not at its reset value");

  // partner word only moves on a capture strobe
  a_part_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !partner_page_valid |=> $stable(partner_ff))
    else $error("partner word changed without capture");

  a_page_latch: assert property (p_page_latched)
    else $error("page received flag lost");

  a_flags_read_clear: assert property (p_read_clears)
    else $error("latched flags not cleared by read");

  // local next-page flag is set by its capability input and held until an expansion read
  a_npc_set: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    local_np_capable |=> npc_flag)
    else $error("local next-page flag not set");

  // partner negotiation ability registered once
  a_partner_able: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    1'b1 |=> partner_an_ff == $past(partner_an_able))
    else $error("partner ability not registered");

  // next-page writable bits take the write data
  a_np_write_bits: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    wr_np |=> np_tx_word_ff[pamr_pkg::NP_MORE_BIT]
    == $past(mgmt_wdata[pamr_pkg::NP_MORE_BIT])
    && np_tx_word_ff[pamr_pkg::NP_MSG_BIT]
    == $past(mgmt_wdata[pamr_pkg::NP_MSG_BIT]))
    else $error("next-page write not stored");

  // next-page word only moves on its own write
  a_np_kept: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    !wr_np |=> $stable(np_tx_word_ff))
    else $error("next-page word changed without a write");
endmodule

//--- sim/pamr_mgr_model.sv
/*
  management controller model: one-cycle read and write strobes.
  assumes strobes change on the falling edge of sys_clk.
*/
`timescale 1ns/1ps
module pamr_mgr_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  // idle bus at time zero
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write strobe, data scrambled once released
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
    wdata = ~d;
  endtask

  // one read strobe; answer taken one cycle after the strobe edge
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d,
                        output logic v);
    @(negedge sys_clk);
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk);
    rd = 1'b0;
    v = rvalid;
    d = rdata;
  endtask
endmodule

//--- sim/testbench.sv
/*
  self-checking bench for the negotiation register set.
  assumes inputs move on the falling edge and reads answer in one cycle.
*/
`timescale 1ns/1ps
module testbench;
  logic sys_clk;
  logic rst_n;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr_strobe;
  logic [15:0] adv_word;
  logic [15:0] np_word;
  logic rd;
  logic [15:0] rdata;
  logic rvalid;
  logic an_complete;
  logic pp_valid;
  logic [15:0] pp;
  logic an_able;
  logic page_rx;
  logic pd_fault;
  logic np_cap;
  logic restart;
  int n_fail;
  int comparisons;
  int cyc;

  pamr_regs pamr_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .mgmt_addr(addr), .mgmt_wdata(wdata), .mgmt_wr(wr_strobe),
    .mgmt_rd(rd),
    .mgmt_rdata_ff(rdata), .mgmt_rvalid_ff(rvalid),
    .an_complete(an_complete), .partner_page_valid(pp_valid),
    .partner_page(pp), .partner_an_able(an_able),
    .page_received(page_rx), .par_det_fault(pd_fault),
    .local_np_capable(np_cap), .an_restart_ff(restart),
    .adv_word_ff(adv_word), .np_tx_word_ff(np_word));

  pamr_mgr_model pamr_mgr_model_inst (.sys_clk(sys_clk), .rdata(rdata),
    .rvalid(rvalid), .addr(addr), .wdata(wdata), .wr(wr_strobe),
    .rd(rd));

  // clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read a register and compare data and answer strobe
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    pamr_mgr_model_inst.rd_reg(a, d, v);
    chk(d, exp);
    chk({15'h0000, v}, 16'h0001);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pamr_mgr_model_inst.wr_reg(a, d);
  endtask

  // reset values, unmapped read, write to read-only word
  task automatic t_reset;
    rdchk(pamr_pkg::ADDR_IDENT, {pamr_pkg::ID_ORG_FRAG,
      pamr_pkg::ID_MODEL, pamr_pkg::ID_REV});
    rdchk(pamr_pkg::ADDR_ADV, 16'h01E1);
    rdchk(pamr_pkg::ADDR_PARTNER, 16'h0000);
    rdchk(pamr_pkg::ADDR_EXP, 16'h0004);
    rdchk(pamr_pkg::ADDR_NPTX, 16'h2000);
    rdchk(5'h1F, 16'h0000);
    wr(pamr_pkg::ADDR_IDENT, 16'hFFFF);
    rdchk(pamr_pkg::ADDR_IDENT, {pamr_pkg::ID_ORG_FRAG,
      pamr_pkg::ID_MODEL, pamr_pkg::ID_REV});
    $display("test reset done");
  endtask

  // advertisement masks, restart and no write-back
  task automatic t_adv;
    wr(pamr_pkg::ADDR_ADV, 16'hFFFF);
    chk({15'h0000, restart}, 16'h0001);
    rdchk(pamr_pkg::ADDR_ADV, 16'hADFF);
    chk(adv_word, 16'hADFF);
    chk({15'h0000, restart}, 16'h0000);
    wr(pamr_pkg::ADDR_ADV, 16'h0000);
    rdchk(pamr_pkg::ADDR_ADV, 16'h0000);
    an_complete = 1'b1;
    wr(pamr_pkg::ADDR_ADV, 16'h01E1);
    chk({15'h0000, restart}, 16'h0000);
    pp = 16'h0C1E;
    pp_valid = 1'b1;
    @(negedge sys_clk);
    pp_valid = 1'b0;
    rdchk(pamr_pkg::ADDR_ADV, 16'h01E1);
    chk(adv_word, 16'h01E1);
    $display("test adv done");
  endtask

  // partner page capture and read-only protection
  task automatic t_partner;
    an_able = 1'b1;
    pp = 16'hFFFF;
    pp_valid = 1'b1;
    @(negedge sys_clk);
    pp_valid = 1'b0;
    pp = 16'h0000;
    rdchk(pamr_pkg::ADDR_PARTNER, 16'hEFFF);
    rdchk(pamr_pkg::ADDR_EXP, 16'h000D);
    wr(pamr_pkg::ADDR_PARTNER, 16'h0000);
    rdchk(pamr_pkg::ADDR_PARTNER, 16'hEFFF);
    pp = 16'h6021;
    pp_valid = 1'b1;
    @(negedge sys_clk);
    pp_valid = 1'b0;
    rdchk(pamr_pkg::ADDR_PARTNER, 16'h6021);
    rdchk(pamr_pkg::ADDR_EXP, 16'h0005);
    $display("test partner done");
  endtask

  // latched events hold until read, then clear
  task automatic t_latch;
    pd_fault = 1'b1;
    page_rx = 1'b1;
    @(negedge sys_clk);
    pd_fault = 1'b0;
    page_rx = 1'b0;
    repeat (3) @(negedge sys_clk);
    rdchk(pamr_pkg::ADDR_EXP, 16'h0017);
    rdchk(pamr_pkg::ADDR_EXP, 16'h0005);
    np_cap = 1'b0;
    rdchk(pamr_pkg::ADDR_EXP, 16'h0005);
    rdchk(pamr_pkg::ADDR_EXP, 16'h0001);
    np_cap = 1'b1;
    pd_fault = 1'b1;
    @(negedge sys_clk);
    pd_fault = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rdchk(pamr_pkg::ADDR_EXP, 16'h0005);
    rdchk(pamr_pkg::ADDR_PARTNER, 16'h0000);
    $display("test latch done");
  endtask

  // next-page word writable bits
  task automatic t_np;
    wr(pamr_pkg::ADDR_NPTX, 16'hFFFF);
    rdchk(pamr_pkg::ADDR_NPTX, 16'hA000);
    chk(np_word, 16'hA000);
    wr(pamr_pkg::ADDR_NPTX, 16'h0000);
    rdchk(pamr_pkg::ADDR_NPTX, 16'h0000);
    chk(np_word, 16'h0000);
    $display("test np done");
  endtask

  // verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the ~80 cycles of the run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  // main sequence
  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    rst_n = 1'b0;
    an_complete = 1'b0;
    pp_valid = 1'b0;
    pp = 16'h0000;
    an_able = 1'b0;
    page_rx = 1'b0;
    pd_fault = 1'b0;
    np_cap = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_adv();
    t_partner();
    t_latch();
    t_np();
    results();
  end
endmodule
